/* File: verilog/cbsl_pkg.sv */
// Purpose: Shared constants and types for the commissioning button and status LED block
// Assumes: 50 MHz core clock, APB register access with 32-bit data
// Notes:   Times are in milliseconds; the block counts them on a 1 ms tick
package cbsl_pkg;
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned MS_PER_S        = 1000;
    // Register byte offsets
    localparam logic [7:0]  ADDR_CTRL       = 8'h00;
    localparam logic [7:0]  ADDR_BLINK_TIME = 8'h04;
    localparam logic [7:0]  ADDR_JOIN_STAT  = 8'h08;
    localparam logic [7:0]  ADDR_SIM_BUTTON = 8'h0C;
    localparam logic [7:0]  ADDR_INT_STAT   = 8'h10;
    localparam logic [7:0]  ADDR_INT_MASK   = 8'h14;
    localparam logic [7:0]  ADDR_STATUS     = 8'h18;
    localparam logic [7:0]  ADDR_PERMIT     = 8'h1C;
    // Control field positions and reset values
    localparam int          CTRL_BTN_EN     = 0;
    localparam int          CTRL_LED_EN     = 1;
    localparam int          CTRL_COORD      = 2;
    localparam int          CTRL_FRAMED     = 3;
    localparam logic [3:0]  CTRL_RESET      = 4'h3;
    localparam logic [7:0]  BLINK_RESET     = 8'h00;
    localparam logic [7:0]  PERMIT_RESET    = 8'h00;
    localparam logic [7:0]  PERMIT_ALWAYS   = 8'hFF;
    localparam logic [7:0]  JOINED_CODE     = 8'h00;
    localparam logic [7:0]  FAIL_CODE_BASE  = 8'h20;
    localparam logic [7:0]  NODE_ID_FRAME   = 8'h95;
    // Interrupt bits
    localparam int          INT_PRESS       = 0;
    localparam int          INT_NODE_ID     = 1;
    localparam int          INT_JOIN_CHG    = 2;
    // Times in milliseconds; wake, permit and rapid times built from base times in seconds
    localparam int unsigned WAKE_TIME_S     = 30;
    localparam int unsigned PERMIT_TIME_S   = 60;
    localparam int unsigned RAPID_TIME_S    = 1;
    localparam logic [15:0] WAKE_MS         = 16'(WAKE_TIME_S * MS_PER_S);
    localparam logic [15:0] PERMIT_MS       = 16'(PERMIT_TIME_S * MS_PER_S);
    localparam logic [15:0] RAPID_MS        = 16'(RAPID_TIME_S * MS_PER_S);
    localparam logic [15:0] COORD_BLINK_MS  = 16'd500;
    localparam logic [15:0] OTHER_BLINK_MS  = 16'd250;
    localparam logic [15:0] BLINK_UNIT_MS   = 16'd10;
    localparam logic [15:0] RAPID_TOG_MS    = 16'd50;
    localparam logic [15:0] CODE_ON_MS      = 16'd300;
    localparam logic [15:0] CODE_OFF_MS     = 16'd300;
    localparam logic [15:0] DEBOUNCE_MS     = 16'd20;
    localparam logic [15:0] PRESS_GAP_MS    = 16'd600;
    localparam int unsigned TICK_CYCLES_DEF = CLK_HZ / MS_PER_S;

    typedef enum logic [4:0] {
        LED_UNJOINED = 5'b00001,
        LED_JOINED   = 5'b00010,
        LED_CODE_ON  = 5'b00100,
        LED_CODE_OFF = 5'b01000,
        LED_RAPID    = 5'b10000
    } cbsl_led_state_t;

    // Action requests to the network stack, one-cycle pulses
    typedef struct packed {
        logic nodeIdSend;
        logic permitJoinBcast;
        logic leaveNetwork;
        logic factoryReset;
        logic joinAttempt;
    } cbsl_stack_req_t;
endpackage : cbsl_pkg

/* File: verilog/cbsl_top.sv */
// Purpose: Commissioning button decoder and network status LED driver with APB registers
// Assumes: All inputs synchronous to core_clk; stack acts on one-cycle request pulses
// Notes:   One clock domain; registers reached over APB
// Behaviour
// - Button presses act only while the button enable bit is 1; default on.
// - One press joined: stay awake 30 s and send node identification broadcast.
// - One press unjoined: stay awake 30 s and blink join-failure code.
// - Two presses joined: broadcast one-minute join permit; 0xFF permit setting ignores received permits.
// - Four presses: leave if joined, restore defaults, then attempt to join.
// - Software press count performs exactly the same actions as physical presses; here the software count also acts while the button enable bit is 0.
// - Framed host mode forwards received node identification as frame type 0x95.
// - LED enable 1 (default) drives the indicator pin; otherwise pin released.
// - Unjoined device holds the indicator pin steadily high.
// - Joined device toggles the indicator at the programmed blink interval.
// - Blink setting 0 gives 500 ms coordinator, 250 ms otherwise.
// - Failure code blink count equals join status code minus 0x20.
// - Received node identification blinks indicator rapidly 1 s, then normal.
// - Join status code 0 means joined; nonzero means not joined.
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ns
module cbsl_top
    import cbsl_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
    input  wire logic            core_clk,
    input  wire logic            reset_n,
    input  wire logic            clkEn,
    // APB slave
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [7:0]      paddr,
    input  wire logic [31:0]     pwdata,
    output logic [31:0]          prdata,
    output logic                 pready,
    output logic                 pslverr,
    // Button and indicator
    input  wire logic            buttonPress_n,
    output logic                 ledOut,
    output logic                 ledOe,
    // Network stack side
    input  wire logic [7:0]      joinStatusCode,
    input  wire logic            nodeIdRx,
    input  wire logic            permitJoinRx,
    output cbsl_stack_req_t      stackReq,
    output logic                 awakeHold,
    output logic                 joinPermitOpen,
    output logic                 hostFrameValid,
    output logic [7:0]           hostFrameType,
    output logic                 irq
);
    localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

    logic [3:0]             ctrl_q;
    logic [7:0]             blinkTime_q;
    logic [7:0]             joinPermitTime_q;
    logic [2:0]             intStat_q;
    logic [2:0]             intMask_q;
    logic [31:0]            tickCnt_q;
    logic                   msTick;
    logic                   joined;
    logic                   joinedPrev_q;
    logic                   apbWrite;
    logic                   apbRead;
    logic                   rdLatched_q;
    logic                   simWrite;
    logic                   btnDeb_q;
    logic [15:0]            debCnt_q;
    logic [2:0]             pressCnt_q;
    logic [15:0]            gapCnt_q;
    logic                   dispatch;
    logic [2:0]             dispCount;
    logic [2:0]             lastCount_q;
    logic                   codeReq;
    logic [15:0]            wakeCnt_q;
    logic [15:0]            permitCnt_q;
    cbsl_led_state_t        ledState_q;
    logic [15:0]            ledTimer_q;
    logic [15:0]            rapidCnt_q;
    logic [7:0]             codeLeft_q;
    logic [15:0]            blinkMs;

    // Known register offset check, used for the pslverr response
    function automatic logic addrMapped(input logic [7:0] a);
        case (a)
            ADDR_CTRL, ADDR_BLINK_TIME, ADDR_JOIN_STAT, ADDR_SIM_BUTTON,
            ADDR_INT_STAT, ADDR_INT_MASK, ADDR_STATUS, ADDR_PERMIT: addrMapped = 1'b1;
            default: addrMapped = 1'b0;
        endcase
    endfunction : addrMapped

    assign joined   = (joinStatusCode == JOINED_CODE);
    assign apbWrite = psel && penable && pready && pwrite;
    assign apbRead  = psel && !(penable && pready);
    assign simWrite = apbWrite && (paddr == ADDR_SIM_BUTTON);
    assign pready   = penable && clkEn && rdLatched_q;
    assign pslverr  = pready && !addrMapped(paddr);

    // Software press count takes the same path as a counted button burst
    assign dispatch  = simWrite || (pressCnt_q != 3'd0 && gapCnt_q == 16'd0);
    assign dispCount = simWrite ? pwdata[2:0] : pressCnt_q;
    assign codeReq   = dispatch && dispCount == 3'd1 && !joined;

    // Millisecond tick
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            tickCnt_q <= 32'h0000_0000;
        end else if (clkEn) begin
            tickCnt_q <= (tickCnt_q >= TICK_LAST) ? 32'h0000_0000 : tickCnt_q + 32'd1;
        end
    end
    assign msTick = (tickCnt_q >= TICK_LAST);

    // APB read data latched in setup so it comes from flip-flops
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata      <= 32'h0000_0000;
            rdLatched_q <= 1'b0;
        end else if (clkEn) begin
            rdLatched_q <= apbRead;
            if (apbRead) begin
                case (paddr)
                    ADDR_CTRL:       prdata <= {28'h0000000, ctrl_q};
                    ADDR_BLINK_TIME: prdata <= {24'h000000, blinkTime_q};
                    ADDR_JOIN_STAT:  prdata <= {24'h000000, joinStatusCode};
                    ADDR_INT_STAT:   prdata <= {29'h00000000, intStat_q};
                    ADDR_INT_MASK:   prdata <= {29'h00000000, intMask_q};
                    ADDR_STATUS:     prdata <= {21'h000000, awakeHold, joinPermitOpen,
                                                ledState_q, ledOut, lastCount_q};
                    ADDR_PERMIT:     prdata <= {24'h000000, joinPermitTime_q};
                    default:         prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Configuration registers; four presses restore defaults except the interrupt mask
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q           <= CTRL_RESET;
            blinkTime_q      <= BLINK_RESET;
            joinPermitTime_q <= PERMIT_RESET;
            intMask_q        <= 3'h0;
        end else if (clkEn) begin
            if (dispatch && dispCount == 3'd4) begin
                ctrl_q           <= CTRL_RESET;
                blinkTime_q      <= BLINK_RESET;
                joinPermitTime_q <= PERMIT_RESET;
            end else if (apbWrite) begin
                case (paddr)
                    ADDR_CTRL:       ctrl_q <= pwdata[3:0];
                    ADDR_BLINK_TIME: blinkTime_q <= pwdata[7:0];
                    ADDR_INT_MASK:   intMask_q <= pwdata[2:0];
                    ADDR_PERMIT:     joinPermitTime_q <= pwdata[7:0];
                    default:         ;
                endcase
            end
        end
    end

    // Sticky interrupt status, write one to clear, set wins
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            intStat_q    <= 3'h0;
            joinedPrev_q <= 1'b0;
        end else if (clkEn) begin
            joinedPrev_q <= joined;
            intStat_q    <= (intStat_q & ~((apbWrite && paddr == ADDR_INT_STAT) ?
                                           pwdata[2:0] : 3'h0))
                            | {joined != joinedPrev_q, nodeIdRx, dispatch};
        end
    end
    assign irq = |(intStat_q & intMask_q);

    // Debounce and press grouping
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            btnDeb_q   <= 1'b0;
            debCnt_q   <= 16'h0000;
            pressCnt_q <= 3'h0;
            gapCnt_q   <= 16'h0000;
        end else if (clkEn) begin
            if (btnDeb_q == !buttonPress_n) begin
                debCnt_q <= 16'h0000;
            end else if (msTick) begin
                debCnt_q <= debCnt_q + 16'd1;
            end
            if (dispatch && !simWrite) begin
                pressCnt_q <= 3'h0;
            end
            if (btnDeb_q != !buttonPress_n && msTick && debCnt_q >= DEBOUNCE_MS) begin
                btnDeb_q <= !buttonPress_n;
                debCnt_q <= 16'h0000;
                if (!buttonPress_n && ctrl_q[CTRL_BTN_EN]) begin
                    pressCnt_q <= (pressCnt_q == 3'd7) ? 3'd7 : pressCnt_q + 3'd1;
                    gapCnt_q   <= PRESS_GAP_MS;
                end
            end else if (btnDeb_q && gapCnt_q != 16'h0000) begin
                gapCnt_q <= PRESS_GAP_MS;      // Gap runs from release
            end else if (msTick && gapCnt_q != 16'h0000) begin
                gapCnt_q <= gapCnt_q - 16'd1;
            end
        end
    end

    // Press actions toward the stack
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            stackReq       <= '0;
            lastCount_q    <= 3'h0;
            hostFrameValid <= 1'b0;
            hostFrameType  <= 8'h00;
        end else if (clkEn) begin
            stackReq       <= '0;
            hostFrameValid <= 1'b0;
            if (dispatch) begin
                lastCount_q <= dispCount;
                case (dispCount)
                    3'd1: stackReq.nodeIdSend <= joined;
                    3'd2: stackReq.permitJoinBcast <= joined;
                    3'd4: begin
                        stackReq.leaveNetwork <= joined;
                        stackReq.factoryReset <= 1'b1;
                        stackReq.joinAttempt  <= 1'b1;
                    end
                    default: ;
                endcase
            end
            if (nodeIdRx && ctrl_q[CTRL_FRAMED]) begin
                hostFrameValid <= 1'b1;
                hostFrameType  <= NODE_ID_FRAME;
            end
        end
    end

    // Stay-awake and join-permit windows
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wakeCnt_q   <= 16'h0000;
            permitCnt_q <= 16'h0000;
        end else if (clkEn) begin
            if (dispatch && dispCount == 3'd1) begin
                wakeCnt_q <= WAKE_MS;
            end else if (msTick && wakeCnt_q != 16'h0000) begin
                wakeCnt_q <= wakeCnt_q - 16'd1;
            end
            if ((dispatch && dispCount == 3'd2 && joined) ||
                (permitJoinRx && joinPermitTime_q != PERMIT_ALWAYS)) begin
                permitCnt_q <= PERMIT_MS;
            end else if (msTick && permitCnt_q != 16'h0000) begin
                permitCnt_q <= permitCnt_q - 16'd1;
            end
        end
    end
    assign awakeHold      = (wakeCnt_q != 16'h0000);
    assign joinPermitOpen = (permitCnt_q != 16'h0000) ||
                            (joinPermitTime_q == PERMIT_ALWAYS);

    assign blinkMs = (blinkTime_q == 8'h00) ?
                     (ctrl_q[CTRL_COORD] ? COORD_BLINK_MS : OTHER_BLINK_MS) :
                     16'(blinkTime_q * BLINK_UNIT_MS);

    // Indicator state machine
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ledState_q <= LED_UNJOINED;
            ledOut     <= 1'b1;
            ledTimer_q <= 16'h0000;
            rapidCnt_q <= 16'h0000;
            codeLeft_q <= 8'h00;
        end else if (clkEn) begin
            if (msTick) begin
                ledTimer_q <= ledTimer_q + 16'd1;
            end
            if (nodeIdRx && ctrl_q[CTRL_LED_EN]) begin
                ledState_q <= LED_RAPID;
                ledTimer_q <= 16'h0000;
                rapidCnt_q <= 16'h0000;
            end else if (codeReq && joinStatusCode > FAIL_CODE_BASE) begin
                ledState_q <= LED_CODE_OFF;
                ledOut     <= 1'b0;
                ledTimer_q <= 16'h0000;
                codeLeft_q <= joinStatusCode - FAIL_CODE_BASE;
            end else begin
                case (ledState_q)
                    LED_UNJOINED: begin
                        ledOut <= 1'b1;
                        if (joined) begin
                            ledState_q <= LED_JOINED;
                            ledTimer_q <= 16'h0000;
                        end
                    end
                    LED_JOINED: begin
                        if (!joined) begin
                            ledState_q <= LED_UNJOINED;
                            ledOut     <= 1'b1;
                        end else if (msTick && ledTimer_q + 16'd1 >= blinkMs) begin
                            ledOut     <= !ledOut;
                            ledTimer_q <= 16'h0000;
                        end
                    end
                    LED_CODE_OFF: begin
                        if (msTick && ledTimer_q + 16'd1 >= CODE_OFF_MS) begin
                            ledTimer_q <= 16'h0000;
                            if (codeLeft_q == 8'h00) begin
                                ledState_q <= LED_UNJOINED;
                                ledOut     <= 1'b1;
                            end else begin
                                ledState_q <= LED_CODE_ON;
                                ledOut     <= 1'b1;
                                codeLeft_q <= codeLeft_q - 8'd1;
                            end
                        end
                    end
                    LED_CODE_ON: begin
                        if (msTick && ledTimer_q + 16'd1 >= CODE_ON_MS) begin
                            ledState_q <= LED_CODE_OFF;
                            ledOut     <= 1'b0;
                            ledTimer_q <= 16'h0000;
                        end
                    end
                    LED_RAPID: begin
                        if (msTick) begin
                            rapidCnt_q <= rapidCnt_q + 16'd1;
                        end
                        if (msTick && rapidCnt_q + 16'd1 >= RAPID_MS) begin
                            ledState_q <= joined ? LED_JOINED : LED_UNJOINED;
                            ledOut     <= 1'b1;
                            ledTimer_q <= 16'h0000;
                        end else if (msTick && ledTimer_q + 16'd1 >= RAPID_TOG_MS) begin
                            ledOut     <= !ledOut;
                            ledTimer_q <= 16'h0000;
                        end
                    end
                    default: begin
                        ledState_q <= LED_UNJOINED;
                        ledOut     <= 1'b1;
                    end
                endcase
            end
        end
    end
    assign ledOe = ctrl_q[CTRL_LED_EN];

endmodule : cbsl_top

/* File: testbench/cbsl_properties.sv */
// Purpose: Port-level checks of the commissioning and status block
// Assumes: Only the top-level ports are visible
// Notes:   Bound to every cbsl_top instance
`timescale 1ns/1ns
module cbsl_checker
    import cbsl_pkg::*;
(
    input wire logic            core_clk,
    input wire logic            reset_n,
    input wire logic            psel,
    input wire logic            penable,
    input wire logic            pready,
    input wire logic            pslverr,
    input wire logic            ledOut,
    input wire logic            ledOe,
    input wire logic [7:0]      joinStatusCode,
    input wire logic            nodeIdRx,
    input wire cbsl_stack_req_t stackReq,
    input wire logic            joinPermitOpen,
    input wire logic            hostFrameValid,
    input wire logic [7:0]      hostFrameType
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    sequence s_rx_led;
        nodeIdRx && ledOe;
    endsequence
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    a_slverr_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_frame_type: assert property (hostFrameValid |-> hostFrameType == NODE_ID_FRAME)
        else $error("wrong host frame type");
    a_frame_cause: assert property (hostFrameValid |-> $past(nodeIdRx))
        else $error("host frame without received broadcast");
    a_ident_pulse: assert property (stackReq.nodeIdSend |=> !stackReq.nodeIdSend)
        else $error("broadcast request longer than one cycle");
    a_ident_joined: assert property (stackReq.nodeIdSend |-> $past(joinStatusCode) == JOINED_CODE)
        else $error("broadcast requested while not joined");
    a_permit_joined: assert property (stackReq.permitJoinBcast |-> $past(joinStatusCode) == JOINED_CODE)
        else $error("join permit requested while not joined");
    a_permit_open: assert property ($rose(stackReq.permitJoinBcast) |-> ##[0:2] joinPermitOpen)
        else $error("local permit window not opened");
    a_rapid_start: assert property (s_rx_led |-> ##[1:60] ledOut != $past(ledOut))
        else $error("no rapid blink after received broadcast");
endmodule : cbsl_checker
bind cbsl_top cbsl_checker u_chk (.core_clk, .reset_n, .psel, .penable, .pready, .pslverr,
    .ledOut, .ledOe, .joinStatusCode, .nodeIdRx, .stackReq, .joinPermitOpen,
    .hostFrameValid, .hostFrameType);

/* File: testbench/cbsl_far_side.sv */
// Purpose: Pushbutton and network stack model
// Assumes: Driven from tb_top through its tasks
// Notes:   Leaving the network reports an unjoined code
`timescale 1ns/1ns
module cbsl_far_side
    import cbsl_pkg::*;
(
    input wire logic            core_clk,
    input wire cbsl_stack_req_t stackReq,
    output logic [7:0]          joinStatusCode,
    output logic                nodeIdRx,
    output logic                permitJoinRx,
    output logic                buttonPress_n
);
    initial begin
        joinStatusCode = 8'h22;
        nodeIdRx       = 1'b0;
        permitJoinRx   = 1'b0;
        buttonPress_n  = 1'b1;
    end
    always @(posedge core_clk) begin
        if (stackReq.leaveNetwork) begin
            joinStatusCode <= 8'h21;
        end
    end
    task automatic set_code(input logic [7:0] c);
        @(posedge core_clk);
        joinStatusCode <= c;
    endtask : set_code
    task automatic pulse_rx;
        @(posedge core_clk);
        nodeIdRx <= 1'b1;
        @(posedge core_clk);
        nodeIdRx <= 1'b0;
    endtask : pulse_rx
    task automatic press(input int n);
        repeat (n) begin
            @(posedge core_clk);
            buttonPress_n <= 1'b0;
            repeat (40) @(posedge core_clk);
            buttonPress_n <= 1'b1;
            repeat (100) @(posedge core_clk);
        end
    endtask : press
endmodule : cbsl_far_side

/* File: testbench/tb_top.sv */
// Purpose: Self-checking bench for cbsl_top
// Assumes: One tick per clock cycle
// Notes:   Far side held in cbsl_far_side
`timescale 1ns/1ns
module tb_top
    import cbsl_pkg::*;
;
    typedef struct packed { logic [7:0] code; logic [2:0] cnt; logic [4:0] req; } cbsl_row_t;
    localparam cbsl_row_t ROWS [7] = '{'{8'h00, 3'd1, 5'h10}, '{8'h22, 3'd1, 5'h00},
        '{8'h00, 3'd2, 5'h08}, '{8'h22, 3'd2, 5'h00}, '{8'h00, 3'd3, 5'h00},
        '{8'h00, 3'd4, 5'h07}, '{8'h22, 3'd4, 5'h03}};
    logic            core_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0;
    logic            pwrite = 1'b0, pready, pslverr, err, ledOut, ledOe, prevLed;
    logic            buttonPress_n, nodeIdRx, permitJoinRx, awakeHold, joinPermitOpen;
    logic            hostFrameValid, irq;
    logic [7:0]      paddr = 8'h00, joinStatusCode, hostFrameType, frameSeen;
    logic [31:0]     pwdata = 32'h0, prdata, rd;
    cbsl_stack_req_t stackReq, seen;
    int              n_errors = 0, samples_checked = 0, rises, toggles, p;
    cbsl_top #(.TICK_CYCLES(1)) dut (.core_clk, .reset_n, .clkEn(1'b1), .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .buttonPress_n, .ledOut,
        .ledOe, .joinStatusCode, .nodeIdRx, .permitJoinRx, .stackReq, .awakeHold,
        .joinPermitOpen, .hostFrameValid, .hostFrameType, .irq);
    cbsl_far_side far (.core_clk, .stackReq, .joinStatusCode, .nodeIdRx, .permitJoinRx,
        .buttonPress_n);
    initial begin
        forever #10 core_clk = ~core_clk;
    end
    // Settled-value monitors
    always @(negedge core_clk) begin
        seen = seen | stackReq;
        rises = rises + int'(ledOut && !prevLed);
        toggles = toggles + int'(ledOut != prevLed);
        prevLed = ledOut;
        if (hostFrameValid) begin
            frameSeen = hostFrameType;
        end
    end
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) begin
            @(posedge core_clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb
    task automatic gap(output int q);
        logic l;
        @(negedge core_clk);
        l = ledOut;
        q = 0;
        while (ledOut === l && q < 2000) begin
            @(negedge core_clk);
            q++;
        end
        l = ledOut;
        q = 0;
        while (ledOut === l && q < 2000) begin
            @(negedge core_clk);
            q++;
        end
        @(posedge core_clk);
    endtask : gap
    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (30000) @(posedge core_clk);
        n_errors++;
        final_report();
    end
    initial begin
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        apb(1'b0, ADDR_CTRL, 32'h0);
        check("ctrl", rd, 32'(CTRL_RESET));
        apb(1'b0, ADDR_BLINK_TIME, 32'h0);
        check("blink", rd, 32'(BLINK_RESET));
        apb(1'b0, 8'h20, 32'h0);
        check("unmapped", {rd[30:0], err}, 32'h1);
        check("permit idle", 32'(joinPermitOpen), 32'h0);
        $display("test reset done");
        foreach (ROWS[i]) begin
            far.set_code(ROWS[i].code);
            seen = '0;
            apb(1'b1, ADDR_SIM_BUTTON, {29'h0, ROWS[i].cnt});
            repeat (8) @(posedge core_clk);
            check("stackReq", 32'(seen), 32'(ROWS[i].req));
        end
        check("permit open", 32'(joinPermitOpen), 32'h1);
        $display("test press table done");
        far.set_code(8'h22);
        apb(1'b1, ADDR_INT_STAT, 32'h7);
        apb(1'b1, ADDR_INT_MASK, 32'h1);
        check("irq idle", 32'(irq), 32'h0);
        apb(1'b1, ADDR_SIM_BUTTON, 32'h1);
        rises = 0;
        repeat (4) @(posedge core_clk);
        check("irq", 32'(irq), 32'h1);
        check("awake", 32'(awakeHold), 32'h1);
        apb(1'b1, ADDR_INT_STAT, 32'h1);
        check("irq cleared", 32'(irq), 32'h0);
        repeat (2100) @(posedge core_clk);
        check("code rises", 32'(rises), 32'h3);
        check("steady", 32'(ledOut), 32'h1);
        $display("test failure code done");
        far.set_code(JOINED_CODE);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, ADDR_CTRL, i == 1 ? 32'h7 : 32'h3);
            apb(1'b1, ADDR_BLINK_TIME, i == 2 ? 32'h3 : 32'h0);
            gap(p);
            check("interval", 32'(p), i == 0 ? 32'd250 : (i == 1 ? 32'd500 : 32'd30));
        end
        $display("test joined blink done");
        apb(1'b1, ADDR_CTRL, 32'hB);
        far.pulse_rx();
        toggles = 0;
        repeat (975) @(posedge core_clk);
        check("rapid", 32'(toggles >= 18 && toggles <= 20), 32'h1);
        check("frame", 32'(frameSeen), 32'(NODE_ID_FRAME));
        apb(1'b1, ADDR_CTRL, 32'h1);
        check("oe off", 32'(ledOe), 32'h0);
        $display("test node ident done");
        apb(1'b1, ADDR_CTRL, 32'h3);
        seen = '0;
        far.press(2);
        repeat (800) @(posedge core_clk);
        check("button two", 32'(seen), 32'h8);
        apb(1'b1, ADDR_CTRL, 32'h2);
        seen = '0;
        far.press(1);
        repeat (800) @(posedge core_clk);
        check("button off", 32'(seen), 32'h0);
        $display("test button done");
        final_report();
    end
endmodule : tb_top
